// ### src/wdg_top.v
// Watchdog timer with reset-cause status, reached over AHB-Lite.
// Assumes all inputs synchronous to hclk; hresetn is the power-on reset.
`include "wdg_regs.vh"

module wdg_top #(
  parameter BASE_PERIOD = `WDG_BASE_PERIOD
) (
  // Clock and power-on reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Core side
  input wire global_int_enable,
  input wire wdt_vector_ack,
  input wire wdt_restart,
  input wire osc_tick,
  output wire wdt_irq,
  // Reset system
  input wire always_on_fuse,
  input wire debug_port_reset,
  input wire brownout_reset,
  input wire external_pin_reset,
  output reg watchdog_reset
);

  // Bus data phase state
  reg dp_wr;
  reg dp_cause;
  reg dp_ctrl;
  reg rd_wait;

  // Control register state
  reg int_flag;
  reg int_en;
  reg [3:0] psel;
  reg ce;
  reg [2:0] ce_cnt;
  reg re;

  // Next values
  reg next_if;
  reg next_ie;
  reg [3:0] next_psel;
  reg next_ce;
  reg [2:0] next_ce_cnt;
  reg next_re;
  reg sel_cause;
  reg sel_ctrl;
  reg [7:0] rd_mux;

  wire take;
  wire wr_ctrl;
  wire wr_cause;
  wire [7:0] wd;
  wire [4:0] cause;
  wire watchdog_reset_cause_flag;
  wire fuse_on;
  wire re_eff;
  wire ie_eff;
  wire run;
  wire timeout;
  wire wd_fire;
  wire set_if;
  wire sys_rst;
  wire ack_comb;

  // ---- AHB-Lite slave ----

  // Address phase is taken only while the bus is ready
  assign take = hsel & hready & htrans[1];

  // Reads hold one wait state so data comes from a flop
  assign hreadyout = ~rd_wait;
  assign hresp = 1'b0;

  // Address decode; anything else reads zero and ignores writes
  always @* begin
    sel_cause = 1'b0;
    sel_ctrl = 1'b0;
    if (haddr == {22'h000000, `WDG_IDX_CAUSE, 2'h0}) begin
      sel_cause = 1'b1;
    end else if (haddr == {22'h000000, `WDG_IDX_CTRL, 2'h0}) begin
      sel_ctrl = 1'b1;
    end
  end

  // Capture the address phase; non-word writes are ignored
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_cause <= 1'b0;
      dp_ctrl <= 1'b0;
    end else if (take) begin
      dp_wr <= hwrite & (hsize == `WDG_HSIZE_WORD);
      dp_cause <= sel_cause;
      dp_ctrl <= sel_ctrl;
    end else if (hreadyout) begin
      dp_wr <= 1'b0;
    end
  end

  // Read wait state and read data register
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_wait <= 1'b0;
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      rd_wait <= 1'b1;
    end else if (rd_wait) begin
      rd_wait <= 1'b0;
      hrdata <= {24'h000000, rd_mux};
    end
  end

  // Write strobes act at the end of the data phase
  assign wr_ctrl = dp_wr & dp_ctrl;
  assign wr_cause = dp_wr & dp_cause;
  assign wd = hwdata[7:0];

  // ---- Mode selection ----

  // Fuse input low means programmed
  assign fuse_on = ~always_on_fuse;

  // Programmed fuse locks reset on and interrupt off
  assign re_eff = re | fuse_on;
  assign ie_eff = int_en & ~fuse_on;

  // Stopped only when neither action is selected
  assign run = re_eff | ie_eff;

  // Combined mode resets only if the flag is still pending
  assign wd_fire = timeout & re_eff & (~ie_eff | int_flag);
  assign set_if = timeout & ie_eff;

  // Any system reset other than power-on
  assign sys_rst = watchdog_reset | debug_port_reset |
                   brownout_reset | external_pin_reset;

  assign ack_comb = wdt_vector_ack & int_flag;

  // Request to the core only with both enables
  assign wdt_irq = int_flag & ie_eff & global_int_enable;

  // ---- Reset-cause flags ----

  wdg_cause_flags u_flags (
    .hclk(hclk),
    .hresetn(hresetn),
    .set_evt({debug_port_reset, wd_fire, brownout_reset,
              external_pin_reset, 1'b0}),
    .wr_en(wr_cause),
    .wr_data(wd[4:0]),
    .flags(cause)
  );

  assign watchdog_reset_cause_flag = cause[`WDG_CS_WD];

  // ---- Counter ----

  wdg_counter #(
    .BASE_PERIOD(BASE_PERIOD)
  ) u_counter (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(run),
    .restart(wdt_restart | sys_rst),
    .osc_tick(osc_tick),
    .psel(psel),
    .timeout(timeout)
  );

  // ---- Control register next state ----

  // System resets return the control bits to their initial values, except RE while the watchdog cause flag is set
  always @* begin
    next_if = int_flag;
    next_ie = int_en;
    next_psel = psel;
    next_ce = ce;
    next_ce_cnt = ce_cnt;
    next_re = re;
    if (sys_rst) begin
      next_if = 1'b0;
      next_ie = 1'b0;
      next_psel = `WDG_PSEL_RST;
      next_ce = 1'b0;
      next_ce_cnt = 3'h0;
      next_re = 1'b0;
    end else begin
      // Flag: a new time-out beats any clear
      if (set_if) begin
        next_if = 1'b1;
      end else if (ack_comb) begin
        next_if = 1'b0;
      end else if (wr_ctrl && wd[`WDG_CTL_IF]) begin
        next_if = 1'b0;
      end
      // Enable: vector in combined mode drops to reset-only
      if (wr_ctrl) begin
        next_ie = wd[`WDG_CTL_IE];
      end
      if (ack_comb && re_eff) begin
        next_ie = 1'b0;
      end
      // Change-enable window of four clocks
      if (wr_ctrl && wd[`WDG_CTL_CE]) begin
        next_ce = 1'b1;
        next_ce_cnt = `WDG_CE_CYCLES;
      end else if (ce) begin
        next_ce_cnt = ce_cnt - 3'h1;
        if (ce_cnt == 3'h1) begin
          next_ce = 1'b0;
        end
      end
      // PSEL and clearing RE open only inside the window; RE can also be set outside it
      if (wr_ctrl && ce) begin
        next_psel = {wd[`WDG_CTL_P3], wd[2:0]};
        next_re = wd[`WDG_CTL_RE];
      end else if (wr_ctrl) begin
        next_re = re | wd[`WDG_CTL_RE];
      end
    end
    // Cause flag keeps reset enabled
    next_re = next_re | watchdog_reset_cause_flag;
  end

  // Control register flops
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_flag <= 1'b0;
      int_en <= 1'b0;
      psel <= `WDG_PSEL_RST;
      ce <= 1'b0;
      ce_cnt <= 3'h0;
      re <= 1'b0;
    end else begin
      int_flag <= next_if;
      int_en <= next_ie;
      psel <= next_psel;
      ce <= next_ce;
      ce_cnt <= next_ce_cnt;
      re <= next_re;
    end
  end

  // One-cycle watchdog reset pulse to the reset system
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= wd_fire;
    end
  end

  // ---- Read data ----

  // Reads show locked enables as the mode really is
  always @* begin
    rd_mux = 8'h00;
    if (dp_cause) begin
      rd_mux = {3'h0, cause};
    end else if (dp_ctrl) begin
      rd_mux = {int_flag, ie_eff, psel[3], ce, re_eff, psel[2:0]};
    end
  end

endmodule // wdg_top

// ### src/wdg_regs.vh
// Register map, field positions, reset values and timing counts of the
// watchdog block. Assumes the includer works on 32-bit AHB-Lite words.
`ifndef WDG_REGS_VH
`define WDG_REGS_VH

// Register indexes; the byte address is four times the index
`define WDG_IDX_CAUSE 8'h55
`define WDG_IDX_CTRL 8'h60

// Control register fields
`define WDG_CTL_IF 7
`define WDG_CTL_IE 6
`define WDG_CTL_P3 5
`define WDG_CTL_CE 4
`define WDG_CTL_RE 3

// Reset-cause register fields
`define WDG_CS_DBG 4
`define WDG_CS_WD 3
`define WDG_CS_BO 2
`define WDG_CS_EXT 1
`define WDG_CS_POR 0

// Reset values
`define WDG_CAUSE_RST 5'h01
`define WDG_PSEL_RST 4'h0

// Timing
`define WDG_CE_CYCLES 3'h4
`define WDG_BASE_PERIOD 2048
`define WDG_PSEL_MAX 4'h9

// Bus encodings
`define WDG_HSIZE_WORD 3'h2

`endif

// ### src/wdg_counter.v
// Time-out counter of the watchdog, counting oscillator ticks.
// Assumes osc_tick is a one-cycle pulse synchronous to hclk.
`include "wdg_regs.vh"

module wdg_counter #(
  parameter BASE_PERIOD = `WDG_BASE_PERIOD
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Control
  input wire run,
  input wire restart,
  input wire osc_tick,
  input wire [3:0] psel,
  // Event
  output wire timeout
);

  reg [20:0] count;
  wire [20:0] last;

  // Last count of a period; reserved selects give the longest period
  function [20:0] wdg_last;
    input [3:0] sel;
    reg [31:0] p;
    begin
      p = BASE_PERIOD;
      if (sel > `WDG_PSEL_MAX) begin
        p = p << `WDG_PSEL_MAX;
      end else begin
        p = p << sel;
      end
      wdg_last = p[20:0] - 21'h000001;
    end
  endfunction

  assign last = wdg_last(psel);

  // A shorter period chosen late ends at once, hence the compare
  assign timeout = run & osc_tick & (count >= last);

  // Back to zero on restart and after every time-out
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 21'h000000;
    end else if (!run || restart) begin
      count <= 21'h000000;
    end else if (timeout) begin
      count <= 21'h000000;
    end else if (osc_tick) begin
      count <= count + 21'h000001;
    end
  end

endmodule // wdg_counter

// ### src/wdg_cause_flags.v
// Sticky reset-cause flags of the status register.
// Assumes hresetn is the power-on reset and set pulses are synchronous.
`include "wdg_regs.vh"

module wdg_cause_flags (
  // Clock and power-on reset
  input wire hclk,
  input wire hresetn,
  // Cause events
  input wire [4:0] set_evt,
  // Software write
  input wire wr_en,
  input wire [4:0] wr_data,
  // Flags
  output wire [4:0] flags
);

  reg [4:0] flag;
  wire [4:0] rst_val;

  assign rst_val = `WDG_CAUSE_RST;
  assign flags = flag;

  // Set beats a software clear in the same cycle
  genvar i;
  generate
    for (i = 0; i < 5; i = i + 1) begin : g_flag
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          flag[i] <= rst_val[i];
        end else if (set_evt[i]) begin
          flag[i] <= 1'b1;
        end else if (wr_en && !wr_data[i]) begin
          flag[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule // wdg_cause_flags

// ### test/wdg_props.sv
// Assertion checker for the watchdog top level, bound into wdg_top.
// Assumes hready is fed back from hreadyout by the surroundings.
module wdg_props #(
  parameter BASE_PERIOD = 2048
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Bus answer
  input wire hreadyout,
  input wire hresp,
  // Core and reset system
  input wire osc_tick,
  input wire wdt_restart,
  input wire wdt_vector_ack,
  input wire global_int_enable,
  input wire always_on_fuse,
  input wire wdt_irq,
  input wire watchdog_reset
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [31:0] ticks;
  // Ticks since the last restart; never below the design's own count
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      ticks <= 32'h0;
    else if (watchdog_reset || wdt_restart)
      ticks <= 32'h0;
    else
      ticks <= ticks + {31'h0, osc_tick};
  end
  a_fuse_no_irq: assert property (!always_on_fuse |-> !wdt_irq)
    else $error("interrupt raised with fuse programmed");
  a_irq_needs_gie: assert property (wdt_irq |-> global_int_enable)
    else $error("interrupt without global enable");
  a_reset_from_tick: assert property (watchdog_reset |-> $past(osc_tick))
    else $error("watchdog reset without oscillator tick");
  a_reset_single: assert property (watchdog_reset |=> !watchdog_reset)
    else $error("watchdog reset longer than one cycle");
  a_period_floor: assert property (watchdog_reset |-> ticks >= BASE_PERIOD - 1)
    else $error("watchdog reset before shortest period");
  a_ack_drops_irq: assert property (wdt_vector_ack && !osc_tick |=> !wdt_irq)
    else $error("interrupt still up after vector");
  a_wait_one: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  a_resp_okay: assert property (hresp == 1'h0)
    else $error("error response seen");
  c_wdog_reset: cover property (watchdog_reset);
  c_irq: cover property ($rose(wdt_irq));
  c_ack: cover property (wdt_irq && wdt_vector_ack);
endmodule // wdg_props

bind wdg_top wdg_props #(.BASE_PERIOD(BASE_PERIOD)) u_props (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .osc_tick(osc_tick), .wdt_restart(wdt_restart),
  .wdt_vector_ack(wdt_vector_ack), .global_int_enable(global_int_enable),
  .always_on_fuse(always_on_fuse), .wdt_irq(wdt_irq),
  .watchdog_reset(watchdog_reset)
);

// ### test/test_watchdog_with_reset_flags.sv
// Self-checking bench for the watchdog top level over AHB-Lite.
// Assumes wdg_props is bound in; the bench plays core and oscillator.
`include "wdg_regs.vh"

module test_watchdog_with_reset_flags;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] CAUSE = {22'h0, `WDG_IDX_CAUSE, 2'h0};
  localparam logic [31:0] CTRL = {22'h0, `WDG_IDX_CTRL, 2'h0};
  localparam int BP = 4;
  logic hclk = 0, hresetn = 0, hwrite = 0, gie = 0, fuse = 1;
  logic tick_on = 0, osc_tick = 0, was_low = 0;
  logic [31:0] haddr = 0, hwdata = 0, rnd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0, tc = 0;
  logic [4:0] pin = 0;
  logic [7:0] exp_q[$];
  logic [7:0] cum[3] = '{8'h11, 8'h15, 8'h17};
  wire hreadyout, hresp, wdt_irq, watchdog_reset;
  wire [31:0] hrdata;
  wire [1:0] ev = {watchdog_reset, wdt_irq};
  int bad_count = 0, checks_done = 0, nt;

  wdg_top #(.BASE_PERIOD(BP)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .global_int_enable(gie), .wdt_vector_ack(pin[3]),
    .wdt_restart(pin[4]), .osc_tick(osc_tick), .wdt_irq(wdt_irq),
    .always_on_fuse(fuse), .debug_port_reset(pin[0]),
    .brownout_reset(pin[1]), .external_pin_reset(pin[2]),
    .watchdog_reset(watchdog_reset)
  );

  always #25 hclk = ~hclk;

  // Oscillator ticks every eighth cycle, gated so tests can freeze time
  always @(posedge hclk) begin
    tc <= tc + 3'h1;
    osc_tick <= tick_on && tc == 3'h0;
  end

  // Read data is valid once the single wait state has passed
  always @(posedge hclk) begin
    if (was_low && hreadyout)
      chk("hrdata", hrdata[7:0], exp_q.pop_front());
    was_low <= !hreadyout;
  end

  task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // Level read at the falling edge equals what the next rising edge sees
  task rdy_edge;
    logic r;
    do begin
      @(negedge hclk) r = hreadyout;
      @(posedge hclk);
    end while (!r);
  endtask

  task bus(input logic w, input logic [31:0] a, input logic [7:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= `WDG_HSIZE_WORD;
    rdy_edge;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    rdy_edge;
  endtask

  task wr(input logic [31:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask

  task rd(input logic [31:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'h0, a, 8'h0);
  endtask

  task pulse(input int k);
    pin[k] <= 1'h1;
    @(posedge hclk);
    pin[k] <= 1'h0;
    @(posedge hclk);
  endtask

  // Let the oscillator run until the event shows, counting its ticks
  task run_until(input int k);
    int i;
    nt = 0;
    tick_on <= 1'h1;
    for (i = 0; i < 3000 && ev[k] !== 1'h1; i++) begin
      @(negedge hclk);
      nt += osc_tick && ev[k] !== 1'h1;
    end
    chk("event", ev[k], 1'h1);
    @(posedge hclk);
    tick_on <= 1'h0;
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    rnd = $urandom(6370);
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rd(CAUSE, 8'h01);
    rd(CTRL, 8'h00);
    rd(32'h200, 8'h00);
    $display("test reset values done");
    for (int k = 0; k < 3; k++) begin
      pulse(k);
      rd(CAUSE, cum[k]);
    end
    rnd = $urandom;
    wr(CAUSE, rnd[7:0]);
    rd(CAUSE, {3'h0, rnd[4:0]} & 8'h17);
    wr(CAUSE, 8'h00);
    rd(CAUSE, 8'h00);
    $display("test cause flags done");
    gie <= 1'h1;
    wr(CTRL, 8'h40);
    run_until(0);
    rd(CTRL, 8'hC0);
    gie <= 1'h0;
    @(negedge hclk);
    chk("irq", wdt_irq, 1'h0);
    @(posedge hclk);
    gie <= 1'h1;
    wr(CTRL, 8'hC0);
    rd(CTRL, 8'h40);
    run_until(0);
    pulse(3);
    rd(CTRL, 8'h40);
    $display("test interrupt mode done");
    wr(CTRL, 8'h48);
    run_until(0);
    rd(CTRL, 8'hC8);
    pulse(3);
    rd(CTRL, 8'h08);
    wr(CTRL, 8'h48);
    run_until(0);
    run_until(1);
    rd(CTRL, 8'h08);
    rd(CAUSE, 8'h08);
    $display("test combined mode done");
    wr(CTRL, 8'h00);
    rd(CTRL, 8'h08);
    wr(CAUSE, 8'h00);
    wr(CTRL, 8'h00);
    rd(CTRL, 8'h08);
    wr(CTRL, 8'h18);
    wr(CTRL, 8'h27);
    // Change-enable still stands: the read lands inside its window
    rd(CTRL, 8'h37);
    wr(CTRL, 8'h10);
    rd(CTRL, 8'h37);
    repeat (4) @(posedge hclk);
    rd(CTRL, 8'h27);
    wr(CTRL, 8'h20);
    rd(CTRL, 8'h27);
    $display("test timed sequence done");
    for (int s = 0; s < 3; s++) begin
      pulse(4);
      wr(CTRL, 8'h18);
      wr(CTRL, 8'hC0 | s[7:0]);
      run_until(0);
      chk("ticks", nt[7:0], 8'(BP << s));
    end
    $display("test periods done");
    wr(CTRL, 8'h80);
    fuse <= 1'h0;
    rd(CTRL, 8'h0A);
    run_until(1);
    rd(CTRL, 8'h08);
    rd(CAUSE, 8'h08);
    $display("test fuse done");
    end_sim;
  end

  // Whole run needs under a thousand cycles; cut a hang well beyond that
  initial begin
    #1000000;
    bad_count++;
    end_sim;
  end
endmodule // test_watchdog_with_reset_flags
